// File: speaker_fault_detect.sv
// Speaker amplifier control, open-load and short fault detection with AXI4-Lite registers
//
// Overview of operation
// - Interval field bits 1-3 sets stuck judgment
// - Count field bits 4-6 sets short count
// - Zero continuous, 1-6 doubling counts, seven off
// - Continuous mode: one short stops playback, flags
// - Counted modes sample each 2us, consecutive count
// - Bit 7 read-only fault flag, either cause
// - Fault raises interrupt, then resets PWM
// - One enable switches both fault detectors
// - Stuck-high flags after selected interval elapses
// - Amp enable starts amp; clear tri-states pins
// - PLL stop while amp on records reset
// - Open detector enable, read-only result flag
// - Fault detectors act only with amp and playback
// - Interval doubles from 62.5us; high gain 8,12,16,24.. ms; seven off
//
// Added by the designer: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
`include "speaker_fault_map.svh"
module speaker_fault_detect
  import speaker_fault_pkg::*;
#(
  parameter int SAMPLE_CYC   = `SAMPLE_CYCLES,
  parameter int LOW_BASE_CYC = `BASE_INTERVAL_CYC,
  parameter int HI_BASE_CYC  = `HIGH_GAIN_BASE_CYC,
  parameter int PLL_STOP_CYC = `PLL_STOP_CYC
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Analog and pin inputs (asynchronous)
  input  wire logic        pwm_high_raw,
  input  wire logic        pin_short_raw,
  input  wire logic        open_detect_raw,
  input  wire logic        pll_running_raw,
  // Playback engine
  input  wire logic        voice_playback_enable,
  input  wire logic        pwm_pos,
  input  wire logic        pwm_neg,
  output logic             playback_stop,
  output logic             pwm_reset,
  output logic             device_reset_req,
  // Speaker pins
  output logic             speaker_out_pos,
  output logic             speaker_out_pos_oe,
  output logic             speaker_out_neg,
  output logic             speaker_out_neg_oe,
  output logic             amp_power_on,
  output logic             open_detect_power_on,
  // Interrupt
  output logic             irq
);
  ////////////////////////////////////////////////////////////////////////////
  logic        amp_enable_q, input_gain_sel_q, open_detect_enable_q;
  logic        fault_detect_enable_q, fault_result_flag_q, pll_stop_reset_status_q;
  logic [2:0]  stuck_high_interval_sel_q, short_count_sel_q;
  logic [1:0]  irq_status_q, irq_mask_q;
  logic        pwm_high_s, pin_short_s, open_s, pll_run_s;
  logic        aw_hold_q, w_hold_q;
  logic [4:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        wr_fire, rd_fire, armed, fault_set;
  logic [31:0] rd_data_d;
  logic        rd_ok_d, wr_ok;
  logic [31:0] sample_cnt_q, stuck_cnt_q, stuck_limit, pll_cnt_q;
  logic [6:0]  short_run_q, short_need;
  logic        sample_tick;
  logic        stuck_hit, short_hit;
  fault_state_t state_q, state_d;

  // Pin inputs pass two flip-flops before any logic reads them
  sync2 #(.WIDTH(4)) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({pwm_high_raw, pin_short_raw, open_detect_raw, pll_running_raw}),
    .sync_out ({pwm_high_s, pin_short_s, open_s, pll_run_s})
  );

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data may arrive in either order
  assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_q && !s_axi_bvalid;
  assign wr_fire       = aw_hold_q && w_hold_q && !s_axi_bvalid;
  assign wr_ok         = (aw_addr_q[4:2] <= 3'h5);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_q    <= 1'b0;
      w_hold_q     <= 1'b0;
      aw_addr_q    <= 5'h00;
      w_data_q     <= 32'h0000_0000;
      w_strb_q     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped addresses answer SLVERR with zero data
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;

  always_comb
  begin
    rd_data_d = 32'h0000_0000;
    rd_ok_d   = 1'b1;
    case ({s_axi_araddr[4:2], 2'b00})
      `AMP_CONTROL_OFS:
      begin
        rd_data_d[`AMP_EN_BIT] = amp_enable_q;
        rd_data_d[`GAIN_BIT]   = input_gain_sel_q;
      end
      `OPEN_DETECT_CTRL_OFS:
      begin
        rd_data_d[`OPEN_EN_BIT]   = open_detect_enable_q;
        rd_data_d[`OPEN_FLAG_BIT] = open_detect_enable_q & open_s;
      end
      `FAULT_CONTROL_OFS:
      begin
        rd_data_d[`FAULT_EN_BIT]                 = fault_detect_enable_q;
        rd_data_d[`INTERVAL_MSB:`INTERVAL_LSB]   = stuck_high_interval_sel_q;
        rd_data_d[`COUNT_MSB:`COUNT_LSB]         = short_count_sel_q;
        rd_data_d[`FAULT_FLAG_BIT]               = fault_result_flag_q;
      end
      `RESET_STATUS_OFS: rd_data_d[`PLL_STOP_BIT] = pll_stop_reset_status_q;
      `IRQ_STATUS_OFS:   rd_data_d[1:0] = irq_status_q;
      `IRQ_MASK_OFS:     rd_data_d[1:0] = irq_mask_q;
      default:           rd_ok_d = 1'b0;
    endcase
  end

  // Read data is registered; held until rready
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'h0;
    end
    else if (rd_fire)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_data_d;
      s_axi_rresp  <= rd_ok_d ? 2'h0 : 2'h2;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers; only byte lane 0 carries fields
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      amp_enable_q              <= 1'b0;
      input_gain_sel_q          <= 1'b0;
      open_detect_enable_q      <= 1'b0;
      fault_detect_enable_q     <= 1'b0;
      stuck_high_interval_sel_q <= 3'h0;
      short_count_sel_q         <= 3'h0;
      irq_mask_q                <= 2'h0;
    end
    else if (wr_fire && w_strb_q[0])
    begin
      case ({aw_addr_q[4:2], 2'b00})
        `AMP_CONTROL_OFS:
        begin
          amp_enable_q     <= w_data_q[`AMP_EN_BIT];
          input_gain_sel_q <= w_data_q[`GAIN_BIT];
        end
        `OPEN_DETECT_CTRL_OFS: open_detect_enable_q <= w_data_q[`OPEN_EN_BIT];
        `FAULT_CONTROL_OFS:
        begin
          fault_detect_enable_q     <= w_data_q[`FAULT_EN_BIT];
          stuck_high_interval_sel_q <= w_data_q[`INTERVAL_MSB:`INTERVAL_LSB];
          short_count_sel_q         <= w_data_q[`COUNT_MSB:`COUNT_LSB];
        end
        `IRQ_MASK_OFS: irq_mask_q <= w_data_q[1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Detection is effective only while amp and playback both run
  assign armed = fault_detect_enable_q && amp_enable_q && voice_playback_enable;

  // 2us sampling tick for the counted short modes
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !armed)
      sample_cnt_q <= 32'h0000_0000;
    else if (sample_tick)
      sample_cnt_q <= 32'h0000_0000;
    else
      sample_cnt_q <= sample_cnt_q + 32'h0000_0001;
  end
  assign sample_tick = (sample_cnt_q == 32'(SAMPLE_CYC - 1));

  // Stuck-high limit doubles per code; high gain steps 8,12,16,24.. ms
  always_comb
  begin
    if (!input_gain_sel_q)
      stuck_limit = 32'(LOW_BASE_CYC) << stuck_high_interval_sel_q;
    else if (stuck_high_interval_sel_q[0])
      stuck_limit = (32'(HI_BASE_CYC) + (32'(HI_BASE_CYC) >> 1)) << (stuck_high_interval_sel_q[2:1]);
    else
      stuck_limit = 32'(HI_BASE_CYC) << (stuck_high_interval_sel_q[2:1]);
  end

  // Stuck-high timer restarts whenever the output drops
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !armed || !pwm_high_s || stuck_high_interval_sel_q == `SEL_DISABLED)
      stuck_cnt_q <= 32'h0000_0000;
    else if (!stuck_hit)
      stuck_cnt_q <= stuck_cnt_q + 32'h0000_0001;
  end
  assign stuck_hit = armed && (stuck_high_interval_sel_q != `SEL_DISABLED)
                     && (stuck_cnt_q >= stuck_limit - 32'h0000_0001);

  // Consecutive-short counter; need is 2^code samples
  assign short_need = 7'h01 << short_count_sel_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !armed)
      short_run_q <= 7'h00;
    else if (sample_tick)
      short_run_q <= pin_short_s ? ((short_run_q == 7'h7f) ? short_run_q : short_run_q + 7'h01) : 7'h00;
  end

  always_comb
  begin
    case (short_count_sel_q)
      `SEL_CONTINUOUS: short_hit = armed && pin_short_s;
      `SEL_DISABLED:   short_hit = 1'b0;
      default:         short_hit = armed && sample_tick && pin_short_s
                                   && (short_run_q + 7'h01 >= short_need);
    endcase
  end

  assign fault_set = (stuck_hit || short_hit) && !fault_result_flag_q;

  ////////////////////////////////////////////////////////////////////////////
  // Fault sequencer: flag and interrupt, then one-cycle PWM reset
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      FSM_IDLE:  if (fault_detect_enable_q) state_d = FSM_WATCH;
      FSM_WATCH:
      begin
        if (!fault_detect_enable_q)
          state_d = FSM_IDLE;
        else if (fault_set)
          state_d = FSM_FAULT;
      end
      FSM_FAULT: state_d = FSM_RESET;
      FSM_RESET: if (!fault_detect_enable_q) state_d = FSM_IDLE;
      default:   state_d = FSM_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_q <= FSM_IDLE;
    else
      state_q <= state_d;
  end

  // Flag holds until software drops the shared enable
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !fault_detect_enable_q)
      fault_result_flag_q <= 1'b0;
    else if (state_q == FSM_WATCH && fault_set)
      fault_result_flag_q <= 1'b1;
  end

  // Playback stays stopped while the fault stands; PWM reset follows the interrupt by one cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      playback_stop <= 1'b0;
      pwm_reset     <= 1'b0;
    end
    else
    begin
      playback_stop <= fault_result_flag_q || (state_q == FSM_WATCH && fault_set);
      pwm_reset     <= (state_q == FSM_FAULT);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // PLL stop watchdog while the amp is enabled
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !amp_enable_q || pll_run_s)
      pll_cnt_q <= 32'h0000_0000;
    else if (pll_cnt_q != 32'(PLL_STOP_CYC))
      pll_cnt_q <= pll_cnt_q + 32'h0000_0001;
  end

  // Status: set wins over a software write of zero
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pll_stop_reset_status_q <= 1'b0;
      device_reset_req        <= 1'b0;
    end
    else
    begin
      device_reset_req <= (pll_cnt_q == 32'(PLL_STOP_CYC - 1));
      if (pll_cnt_q == 32'(PLL_STOP_CYC - 1))
        pll_stop_reset_status_q <= 1'b1;
      else if (wr_fire && w_strb_q[0] && {aw_addr_q[4:2], 2'b00} == `RESET_STATUS_OFS
               && !w_data_q[`PLL_STOP_BIT])
        pll_stop_reset_status_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky interrupt status, write one to clear, set wins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_status_q <= 2'h0;
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if ((i == `IRQ_FAULT_BIT && state_q == FSM_WATCH && fault_set)
            || (i == `IRQ_PLL_BIT && pll_cnt_q == 32'(PLL_STOP_CYC - 1)))
          irq_status_q[i] <= 1'b1;
        else if (wr_fire && w_strb_q[0] && aw_addr_q == `IRQ_STATUS_OFS && w_data_q[i])
          irq_status_q[i] <= 1'b0;
      end
    end
  end
  assign irq = |(irq_status_q & irq_mask_q);

  // Pins follow PWM while the amp runs, high impedance otherwise
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      speaker_out_pos <= 1'b0;
      speaker_out_neg <= 1'b0;
    end
    else
    begin
      speaker_out_pos <= amp_enable_q & pwm_pos;
      speaker_out_neg <= amp_enable_q & pwm_neg;
    end
  end
  assign speaker_out_pos_oe   = amp_enable_q;
  assign speaker_out_neg_oe   = amp_enable_q;
  assign amp_power_on         = amp_enable_q;
  assign open_detect_power_on = open_detect_enable_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_flag_needs_enable: assert property (@(posedge aclk) disable iff (!aresetn)
    fault_result_flag_q |-> $past(fault_detect_enable_q)) else $error("flag without enable");
  a_pwm_reset_after: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(fault_result_flag_q) |-> ##1 pwm_reset) else $error("no pwm reset after fault");
  a_irq_on_fault: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(fault_result_flag_q) |-> irq_status_q[`IRQ_FAULT_BIT]) else $error("fault irq missing");
  a_pins_tristate: assert property (@(posedge aclk) disable iff (!aresetn)
    !amp_enable_q |-> !speaker_out_pos_oe && !speaker_out_neg_oe) else $error("pins driven while off");
  a_no_fault_unarmed: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(fault_result_flag_q) |-> $past(armed)) else $error("fault while unarmed");
  a_count_disabled: assert property (@(posedge aclk) disable iff (!aresetn)
    (short_count_sel_q == `SEL_DISABLED) |-> !short_hit) else $error("short when disabled");
  a_continuous_fast: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_q == FSM_WATCH && armed && pin_short_s && short_count_sel_q == `SEL_CONTINUOUS && fault_detect_enable_q)
    ##1 fault_detect_enable_q |-> fault_result_flag_q) else $error("continuous short missed");
  a_run_resets: assert property (@(posedge aclk) disable iff (!aresetn)
    (sample_tick && !pin_short_s && armed) |=> short_run_q == 7'h00) else $error("run not cleared");
  a_stop_follows: assert property (@(posedge aclk) disable iff (!aresetn)
    fault_result_flag_q |=> playback_stop) else $error("playback not stopped");
  a_pll_status: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(device_reset_req) |-> pll_stop_reset_status_q) else $error("pll status not set");
endmodule

// File: speaker_fault_map.svh
// Register offsets, field positions and timing constants for the speaker fault block
`ifndef SPEAKER_FAULT_MAP_SVH
`define SPEAKER_FAULT_MAP_SVH
`define AMP_CONTROL_OFS       5'h00
`define OPEN_DETECT_CTRL_OFS  5'h04
`define FAULT_CONTROL_OFS     5'h08
`define RESET_STATUS_OFS      5'h0c
`define IRQ_STATUS_OFS        5'h10
`define IRQ_MASK_OFS          5'h14
`define AMP_EN_BIT            0
`define GAIN_BIT              1
`define OPEN_EN_BIT           0
`define OPEN_FLAG_BIT         7
`define FAULT_EN_BIT          0
`define INTERVAL_LSB          1
`define INTERVAL_MSB          3
`define COUNT_LSB             4
`define COUNT_MSB             6
`define FAULT_FLAG_BIT        7
`define PLL_STOP_BIT          0
`define IRQ_FAULT_BIT         0
`define IRQ_PLL_BIT           1
`define SEL_CONTINUOUS        3'h0
`define SEL_DISABLED          3'h7
`define CLK_MHZ               100
`define SAMPLE_NS             2000
`define SAMPLE_CYCLES         ((`SAMPLE_NS * `CLK_MHZ) / 1000)
`define BASE_INTERVAL_NS      62500
`define BASE_INTERVAL_CYC     ((`BASE_INTERVAL_NS * `CLK_MHZ) / 1000)
`define HIGH_GAIN_BASE_NS     8000000
`define HIGH_GAIN_BASE_CYC    ((`HIGH_GAIN_BASE_NS * `CLK_MHZ) / 1000)
`define PLL_STOP_NS           10000
`define PLL_STOP_CYC          ((`PLL_STOP_NS * `CLK_MHZ) / 1000)
`endif

// File: speaker_fault_pkg.sv
// Types shared by the speaker fault block
package speaker_fault_pkg;
  typedef enum logic [1:0] {
    FSM_IDLE  = 2'b00,
    FSM_WATCH = 2'b01,
    FSM_FAULT = 2'b11,
    FSM_RESET = 2'b10
  } fault_state_t;
endpackage

// File: speaker_load.sv
// Speaker load model that can short or open the amplifier output pair
`timescale 1ns/1ns
module speaker_load (
  // Output enables of the pair
  input  wire logic speaker_out_pos_oe,
  input  wire logic speaker_out_neg_oe,
  // Fault injection from the bench
  input  wire logic short_en,
  input  wire logic open_en,
  // Comparator levels back to the block
  output logic      pin_short_raw,
  output logic      open_detect_raw
);
  // A short only shows while the pair is driven; a tri-stated pair draws no current
  assign pin_short_raw = short_en & (speaker_out_pos_oe | speaker_out_neg_oe);
  // Open load is a property of the wiring, seen whenever the detector looks
  assign open_detect_raw = open_en;
endmodule

// File: sync2.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  // First stage is read only by the second stage
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_q   <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// File: tb.sv
// Self-checking testbench for the speaker fault block
`timescale 1ns/1ns
`include "speaker_fault_map.svh"
module tb;
  logic        aclk, aresetn, short_en, open_en;
  logic [4:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        pwm_high_raw, pin_short_raw, open_detect_raw, pll_running_raw;
  logic        voice_playback_enable, pwm_pos, pwm_neg, playback_stop, pwm_reset, device_reset_req;
  logic        speaker_out_pos, speaker_out_pos_oe, speaker_out_neg, speaker_out_neg_oe;
  logic        amp_power_on, open_detect_power_on, irq;
  int          miscompares, total_checks, n, p;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing constants scaled down so the whole run stays a few thousand cycles
  speaker_fault_detect #(.SAMPLE_CYC(4), .LOW_BASE_CYC(8), .HI_BASE_CYC(16), .PLL_STOP_CYC(8))
  u_speaker_fault_detect (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .pwm_high_raw, .pin_short_raw, .open_detect_raw, .pll_running_raw, .voice_playback_enable,
    .pwm_pos, .pwm_neg, .playback_stop, .pwm_reset, .device_reset_req, .speaker_out_pos,
    .speaker_out_pos_oe, .speaker_out_neg, .speaker_out_neg_oe, .amp_power_on,
    .open_detect_power_on, .irq
  );
  speaker_load u_speaker_load (
    .speaker_out_pos_oe, .speaker_out_neg_oe, .short_en, .open_en, .pin_short_raw, .open_detect_raw
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    if (miscompares == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rng(input int v, input int lo, input int hi);
    total_checks++;
    if (v < lo || v > hi)
    begin
      miscompares++;
      $display("Error at %0t: %0d cycles outside %0d..%0d", $time, v, lo, hi);
    end
  endtask

  // Address and data offered together; bready stays high so no edge re-drives it
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w))
    begin
      @(posedge aclk);
      aw = aw | s_axi_awready;
      w = w | s_axi_wready;
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rr = s_axi_rresp;
    chk(s_axi_rdata, exp);
  endtask

  // Counts cycles until playback is stopped, giving up at the limit
  task automatic wait_stop(input int lim);
    n = 0;
    while (playback_stop !== 1'b1 && n < lim)
    begin
      @(posedge aclk);
      n++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    for (int a = 0; a < 24; a += 4) rd(5'(a), 32'h0);
    rd(5'h18, 32'h0);
    chk(rr, 2'h2);
    chk(speaker_out_pos_oe, 1'b0);
  endtask

  task automatic t_amp;
    wr(`AMP_CONTROL_OFS, 32'h1);
    repeat (2) @(posedge aclk);
    chk({speaker_out_pos_oe, speaker_out_neg_oe, speaker_out_pos, speaker_out_neg, amp_power_on}, 5'h1d);
    pwm_neg <= 1'b1;
    repeat (2) @(posedge aclk);
    chk(speaker_out_neg, 1'b1);
    pwm_neg <= 1'b0;
    wr(`AMP_CONTROL_OFS, 32'h0);
    repeat (2) @(posedge aclk);
    chk({speaker_out_pos_oe, speaker_out_neg_oe, speaker_out_pos, amp_power_on}, 4'h0);
  endtask

  task automatic t_open;
    open_en <= 1'b1;
    wr(`OPEN_DETECT_CTRL_OFS, 32'h1);
    // Model settles at once, so the settling wait is cut short
    repeat (10) @(posedge aclk);
    rd(`OPEN_DETECT_CTRL_OFS, 32'h81);
    chk(open_detect_power_on, 1'b1);
    open_en <= 1'b0;
    wr(`OPEN_DETECT_CTRL_OFS, 32'h0);
    rd(`OPEN_DETECT_CTRL_OFS, 32'h0);
  endtask

  task automatic t_cont;
    wr(`AMP_CONTROL_OFS, 32'h1);
    wr(`IRQ_MASK_OFS, 32'h1);
    wr(`FAULT_CONTROL_OFS, 32'h0f);
    short_en <= 1'b1;
    wait_stop(20);
    rng(n, 1, 5);
    p = 0;
    repeat (5)
    begin
      @(posedge aclk);
      p += pwm_reset;
    end
    chk(p, 1);
    chk(irq, 1'b1);
    rd(`FAULT_CONTROL_OFS, 32'h8f);
    short_en <= 1'b0;
    wr(`IRQ_MASK_OFS, 32'h0);
    chk(irq, 1'b0);
    wr(`FAULT_CONTROL_OFS, 32'h80);
    rd(`FAULT_CONTROL_OFS, 32'h0);
    chk(playback_stop, 1'b0);
    rd(`IRQ_STATUS_OFS, 32'h1);
    wr(`IRQ_STATUS_OFS, 32'h1);
    rd(`IRQ_STATUS_OFS, 32'h0);
  endtask

  task automatic t_gate;
    short_en <= 1'b1;
    wait_stop(30);
    rng(n, 30, 30);
    voice_playback_enable <= 1'b0;
    wr(`FAULT_CONTROL_OFS, 32'h0f);
    wait_stop(30);
    rng(n, 30, 30);
    voice_playback_enable <= 1'b1;
    wait_stop(20);
    rng(n, 1, 5);
    short_en <= 1'b0;
    wr(`FAULT_CONTROL_OFS, 32'h0);
  endtask

  task automatic t_count;
    // Three short samples, then clean ones, must never add up to four
    wr(`FAULT_CONTROL_OFS, 32'h2f);
    repeat (2)
    begin
      short_en <= 1'b1;
      repeat (10) @(posedge aclk);
      short_en <= 1'b0;
      repeat (10) @(posedge aclk);
    end
    chk(playback_stop, 1'b0);
    wr(`FAULT_CONTROL_OFS, 32'h0);
    for (int c = 1; c < 8; c++)
    begin
      wr(`FAULT_CONTROL_OFS, 32'({c[2:0], 4'hf}));
      short_en <= 1'b1;
      wait_stop(300);
      rng(n, c == 7 ? 300 : ((1 << c) - 1) * 4, c == 7 ? 300 : (1 << c) * 4 + 8);
      short_en <= 1'b0;
      wr(`FAULT_CONTROL_OFS, 32'h0);
    end
  endtask

  task automatic t_stuck;
    int g[5] = '{0, 0, 1, 1, 0};
    int cd[5] = '{0, 2, 1, 6, 7};
    int ex[5] = '{8, 32, 24, 128, 300};
    for (int i = 0; i < 5; i++)
    begin
      wr(`AMP_CONTROL_OFS, 32'(g[i] * 2 + 1));
      wr(`FAULT_CONTROL_OFS, 32'(8'h71 + cd[i] * 2));
      pwm_high_raw <= 1'b1;
      wait_stop(300);
      rng(n, ex[i], ex[i] + 6);
      pwm_high_raw <= 1'b0;
      wr(`FAULT_CONTROL_OFS, 32'h0);
    end
  endtask

  task automatic t_pll;
    wr(`IRQ_MASK_OFS, 32'h2);
    for (int e = 0; e < 2; e++)
    begin
      wr(`AMP_CONTROL_OFS, 32'(e));
      pll_running_raw <= 1'b0;
      p = 0;
      repeat (14)
      begin
        @(posedge aclk);
        p += device_reset_req;
      end
      pll_running_raw <= 1'b1;
      chk(p, e);
      rd(`RESET_STATUS_OFS, 32'(e));
    end
    chk(irq, 1'b1);
    wr(`RESET_STATUS_OFS, 32'h0);
    rd(`RESET_STATUS_OFS, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Free-running 100 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Hang guard, well beyond the few thousand cycles the tests need
  initial
  begin
    #200000;
    miscompares++;
    test_done;
  end

  // Main sequence
  initial
  begin
    {aresetn, short_en, open_en, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, pwm_high_raw, pwm_neg} = '0;
    {s_axi_bready, s_axi_rready, pll_running_raw, voice_playback_enable, pwm_pos} = '1;
    s_axi_wstrb = 4'hf;
    miscompares = 0;
    total_checks = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset;
    t_amp;
    t_open;
    t_cont;
    t_gate;
    t_count;
    t_stuck;
    t_pll;
    test_done;
  end
endmodule
